/* design/general_digital_io_port.sv */
`timescale 1ns/1ps

// Functional notes
// - each pin has a direction bit, an output-value/pull-up bit and a read-only sampled input bit.
// - the port has three separate addresses for output value, direction and sampled input.
// - the sampled input is read-only, output value and direction are read/write.
// - direction one makes the pin an output, zero makes it an input.
// - an output pin is driven to its output-value bit whatever the pull-up disable says.
// - pull-up is on only for direction 0, output value 1 and pull-up disable 0, else input is high-z.
// - global pull-up disable turns off every pull-up.
// - reset tri-states every pin at once, with no clock needed.
// - the input register shows every pin's level whatever its direction.
// - each pad passes a clock-high-transparent latch and then a flip-flop.
// - an external transition shows in the input bit after half to one and a half clock periods.
// - a software-written level reaches the input bit one clock period later, so software waits one instruction.
// - bit set and clear change only the addressed bit of direction or output value.
// - pins given to an alternate function leave the others usable as plain i/o.
module general_digital_io_port (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    // processor i/o access
    input  wire gpio_port_pkg::io_req_type io_req,
    output logic [7:0]                     io_rdata,
    // shared pull-up disable from the special function register
    input  wire logic                      global_pullup_disable,
    // alternate function ownership, one bit per pin
    input  wire logic [7:0]                alt_owned,
    // pads
    input  wire logic [7:0]                pad_in,
    output gpio_port_pkg::pad_ctrl_type    pad_ctrl
);

    logic [7:0] out_value_reg;
    logic [7:0] direction_reg;
    logic [7:0] sampled_reg;
    logic [7:0] out_value_next;
    logic [7:0] direction_next;
    logic [7:0] bit_mask;
    logic [7:0] drive_en_next;
    logic [7:0] pullup_next;

    assign bit_mask = 8'h01 << io_req.bit_index;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    function automatic logic [7:0] apply_op(
        input logic [7:0]               cur,
        input gpio_port_pkg::io_req_type req,
        input logic [7:0]               mask
    );
        logic [7:0] res;
        res = cur;
        case (req.op)
            gpio_port_pkg::OP_WRITE:     res = req.wdata;
            gpio_port_pkg::OP_BIT_SET:   res = cur | mask;
            gpio_port_pkg::OP_BIT_CLEAR: res = cur & ~mask;
            default:                     res = cur;
        endcase
        return res;
    endfunction

    always_comb begin
        out_value_next = out_value_reg;
        direction_next = direction_reg;
        if (io_req.addr == gpio_port_pkg::ADDR_OUTPUT_VALUE) begin
            out_value_next = apply_op(out_value_reg, io_req, bit_mask);
        end else if (io_req.addr == gpio_port_pkg::ADDR_DIRECTION) begin
            direction_next = apply_op(direction_reg, io_req, bit_mask);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_value_reg <= gpio_port_pkg::OUTPUT_VALUE_RESET;
        end else begin
            out_value_reg <= out_value_next;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            direction_reg <= gpio_port_pkg::DIRECTION_RESET;
        end else begin
            direction_reg <= direction_next;
        end
    end

    // ----------------------------------------------------------------
    // pin configuration decode
    // ----------------------------------------------------------------
    // decoded from the next register values so a pin moves at the same
    // edge as the write that configures it, not one cycle later
    always_comb begin
        drive_en_next = direction_next & ~alt_owned;
        pullup_next   = ~direction_next & out_value_next & ~alt_owned;
        if (global_pullup_disable) begin
            pullup_next = 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // pad drive
    // ----------------------------------------------------------------
    // pad controls are pure register bits so reset tri-states them
    // asynchronously; alternate-function pins are left to their owner
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pad_ctrl.drive_value <= 8'h00;
            pad_ctrl.drive_oe_n  <= 8'hff;
            pad_ctrl.pullup_en   <= 8'h00;
        end else begin
            pad_ctrl.drive_value <= out_value_next;
            pad_ctrl.drive_oe_n  <= ~drive_en_next;
            pad_ctrl.pullup_en   <= pullup_next;
        end
    end

    // ----------------------------------------------------------------
    // input sampling, one synchroniser per pin
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < gpio_port_pkg::PORT_WIDTH; gi++) begin : g_sync
            pin_sync u_sync (
                .mclk              (mclk),
                .rst_n             (rst_n),
                .pad_level         (pad_in[gi]),
                .sampled_level_bit (sampled_reg[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            io_rdata <= 8'h00;
        end else begin
            case (io_req.addr)
                gpio_port_pkg::ADDR_SAMPLED_INPUT: io_rdata <= sampled_reg;
                gpio_port_pkg::ADDR_DIRECTION:     io_rdata <= direction_reg;
                gpio_port_pkg::ADDR_OUTPUT_VALUE:  io_rdata <= out_value_reg;
                default:                           io_rdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence set_bit_s;
        io_req.op == gpio_port_pkg::OP_BIT_SET && io_req.addr == gpio_port_pkg::ADDR_DIRECTION;
    endsequence

    sequence out_write_s;
        io_req.op == gpio_port_pkg::OP_WRITE && io_req.addr == gpio_port_pkg::ADDR_OUTPUT_VALUE;
    endsequence

    sequence dir_write_s;
        io_req.op == gpio_port_pkg::OP_WRITE && io_req.addr == gpio_port_pkg::ADDR_DIRECTION;
    endsequence

    bit_set_only_a: assert property (set_bit_s |=> direction_reg == ($past(direction_reg) | $past(bit_mask)))
        else $error("bit set disturbed other direction bits");
    bit_clear_only_a: assert property (io_req.op == gpio_port_pkg::OP_BIT_CLEAR
        && io_req.addr == gpio_port_pkg::ADDR_OUTPUT_VALUE
        |=> out_value_reg == ($past(out_value_reg) & ~$past(bit_mask)))
        else $error("bit clear disturbed other output bits");
    input_read_only_a: assert property (io_req.addr == gpio_port_pkg::ADDR_SAMPLED_INPUT
        |=> out_value_reg == $past(out_value_reg) && direction_reg == $past(direction_reg))
        else $error("input address write changed a register");
    output_drive_a: assert property (1'b1 |=> pad_ctrl.drive_oe_n == ~(direction_reg & ~$past(alt_owned)))
        else $error("output enable does not follow direction");
    drive_level_a: assert property (1'b1 |=> pad_ctrl.drive_value == out_value_reg)
        else $error("drive value does not follow output register");
    pullup_rule_a: assert property (1'b1 |=> pad_ctrl.pullup_en == (~direction_reg & out_value_reg
        & ~$past(alt_owned) & {8{~$past(global_pullup_disable)}}))
        else $error("pull-up enable wrong");
    pullup_disable_a: assert property (global_pullup_disable |=> pad_ctrl.pullup_en == 8'h00)
        else $error("pull-up on while globally disabled");
    no_drive_pullup_a: assert property ((pad_ctrl.pullup_en & ~pad_ctrl.drive_oe_n) == 8'h00)
        else $error("pull-up on a driven pin");
    sync_delay_a: assert property (##1 $stable(pad_in) [*2] |-> sampled_reg == $past(pad_in))
        else $error("sampled level not settled after one period");
    bit_set_out_a: assert property (io_req.op == gpio_port_pkg::OP_BIT_SET
        && io_req.addr == gpio_port_pkg::ADDR_OUTPUT_VALUE
        |=> out_value_reg == ($past(out_value_reg) | $past(bit_mask)))
        else $error("bit set disturbed other output bits");
    bit_clear_dir_a: assert property (io_req.op == gpio_port_pkg::OP_BIT_CLEAR
        && io_req.addr == gpio_port_pkg::ADDR_DIRECTION
        |=> direction_reg == ($past(direction_reg) & ~$past(bit_mask)))
        else $error("bit clear disturbed other direction bits");
    out_write_lands_a: assert property (out_write_s |=> out_value_reg == $past(io_req.wdata))
        else $error("output value write lost");
    dir_write_lands_a: assert property (dir_write_s |=> direction_reg == $past(io_req.wdata))
        else $error("direction write lost");
    write_isolated_a: assert property (dir_write_s |=> out_value_reg == $past(out_value_reg))
        else $error("direction write touched output value");
    // read data is one edge behind the address it answers
    read_direction_a: assert property (io_req.addr == gpio_port_pkg::ADDR_DIRECTION
        |=> io_rdata == $past(direction_reg))
        else $error("direction read back wrong");
    read_output_a: assert property (io_req.addr == gpio_port_pkg::ADDR_OUTPUT_VALUE
        |=> io_rdata == $past(out_value_reg))
        else $error("output value read back wrong");
    read_input_a: assert property (io_req.addr == gpio_port_pkg::ADDR_SAMPLED_INPUT
        |=> io_rdata == $past(sampled_reg))
        else $error("sampled input read back wrong");
    alt_hands_off_a: assert property (1'b1
        |=> ((~pad_ctrl.drive_oe_n | pad_ctrl.pullup_en) & $past(alt_owned)) == 8'h00)
        else $error("drive or pull-up on an alternate-function pin");
    input_no_drive_a: assert property (1'b1 |=> (~pad_ctrl.drive_oe_n & ~direction_reg) == 8'h00)
        else $error("input pin driven");

endmodule

/* design/gpio_port_pkg.sv */
package gpio_port_pkg;

    localparam int PORT_WIDTH = 8;

    // ----------------------------------------------------------------
    // i/o addresses within one port window
    // ----------------------------------------------------------------
    localparam logic [1:0] ADDR_SAMPLED_INPUT = 2'h0;
    localparam logic [1:0] ADDR_DIRECTION     = 2'h1;
    localparam logic [1:0] ADDR_OUTPUT_VALUE  = 2'h2;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] OUTPUT_VALUE_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_RESET    = 8'h00;
    localparam logic [7:0] SAMPLED_RESET      = 8'h00;

    // ----------------------------------------------------------------
    // register access operations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_NONE,
        OP_WRITE,
        OP_BIT_SET,
        OP_BIT_CLEAR
    } io_op_type;

    typedef struct packed {
        io_op_type  op;
        logic [1:0] addr;
        logic [2:0] bit_index;
        logic [7:0] wdata;
    } io_req_type;

    typedef struct packed {
        logic [7:0] drive_value;
        logic [7:0] drive_oe_n;
        logic [7:0] pullup_en;
    } pad_ctrl_type;

endpackage

/* design/pin_sync.sv */
`timescale 1ns/1ps

module pin_sync (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // pad level in, sampled level out
    input  wire logic pad_level,
    output logic      sampled_level_bit
);

    logic sync_latch;

    // transparent while the clock is high, holds while low; the update is
    // deferred so the flop still takes the held value at the opening edge
    always_latch begin
        if (!rst_n) begin
            sync_latch <= 1'b0;
        end else if (mclk) begin
            sync_latch <= pad_level;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sampled_level_bit <= 1'b0;
        end else begin
            sampled_level_bit <= sync_latch;
        end
    end

endmodule

/* verif/general_digital_io_port_tb.sv */
`timescale 1ns/1ps

module general_digital_io_port_tb;
    logic                        mclk;
    logic                        rst_n;
    gpio_port_pkg::io_req_type   io_req;
    logic [7:0]                  io_rdata;
    logic                        global_pullup_disable;
    logic [7:0]                  alt_owned;
    logic [7:0]                  pad_in;
    gpio_port_pkg::pad_ctrl_type pad_ctrl;
    logic [7:0]                  ext_en;
    logic [7:0]                  ext_val;
    int                          bad_count;
    int                          n_tests;

    general_digital_io_port dut_u (.mclk(mclk), .rst_n(rst_n), .io_req(io_req), .io_rdata(io_rdata),
        .global_pullup_disable(global_pullup_disable), .alt_owned(alt_owned), .pad_in(pad_in),
        .pad_ctrl(pad_ctrl));
    pad_partner pads_u (.mclk(mclk), .pad_ctrl(pad_ctrl), .ext_en(ext_en), .ext_val(ext_val),
        .pad_level(pad_in));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic pads(input logic [7:0] oe_n, input logic [7:0] pu);
        chk("drive_oe_n", pad_ctrl.drive_oe_n, oe_n);
        chk("pullup_en", pad_ctrl.pullup_en, pu);
    endtask
    task automatic tick();
        @(posedge mclk);
        #2;
    endtask
    task automatic do_op(input gpio_port_pkg::io_op_type op, input logic [1:0] a, input logic [2:0] b,
                         input logic [7:0] d);
        io_req = '{op, a, b, d};
        tick();
        io_req.op = gpio_port_pkg::OP_NONE;
        // an idle edge keeps back-to-back calls from driving op twice at once
        tick();
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        io_req.addr = a;
        tick();
        chk("io_rdata", io_rdata, exp);
    endtask
    task automatic summarize();
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic reset_values();
        pads(8'hff, 8'h00);
        rd(gpio_port_pkg::ADDR_DIRECTION, 8'h00);
        rd(gpio_port_pkg::ADDR_OUTPUT_VALUE, 8'h00);
        rd(gpio_port_pkg::ADDR_SAMPLED_INPUT, 8'ha5);
        ext_en = 8'h00;
    endtask
    task automatic pullup_cases();
        do_op(gpio_port_pkg::OP_WRITE, gpio_port_pkg::ADDR_OUTPUT_VALUE, 3'h0, 8'hff);
        pads(8'hff, 8'hff);
        global_pullup_disable = 1'b1;
        tick();
        pads(8'hff, 8'h00);
        global_pullup_disable = 1'b0;
        tick();
        // pull-ups reach the pads at one edge, the sampled bits at the next
        tick();
        rd(gpio_port_pkg::ADDR_SAMPLED_INPUT, 8'hff);
    endtask
    task automatic output_drive();
        // pins leave high-z through the pull-up state
        do_op(gpio_port_pkg::OP_WRITE, gpio_port_pkg::ADDR_DIRECTION, 3'h0, 8'h0f);
        pads(8'hf0, 8'hf0);
        global_pullup_disable = 1'b1;
        tick();
        chk("drive_value", pad_ctrl.drive_value & 8'h0f, 8'h0f);
        pads(8'hf0, 8'h00);
        global_pullup_disable = 1'b0;
        tick();
    endtask
    task automatic bit_ops();
        do_op(gpio_port_pkg::OP_BIT_CLEAR, gpio_port_pkg::ADDR_OUTPUT_VALUE, 3'h1, 8'h00);
        chk("drive_value", pad_ctrl.drive_value & 8'h0f, 8'h0d);
        do_op(gpio_port_pkg::OP_BIT_SET, gpio_port_pkg::ADDR_DIRECTION, 3'h7, 8'h00);
        pads(8'h70, 8'h70);
        rd(gpio_port_pkg::ADDR_DIRECTION, 8'h8f);
        rd(gpio_port_pkg::ADDR_OUTPUT_VALUE, 8'hfd);
        do_op(gpio_port_pkg::OP_BIT_SET, gpio_port_pkg::ADDR_OUTPUT_VALUE, 3'h1, 8'h00);
        rd(gpio_port_pkg::ADDR_SAMPLED_INPUT, 8'hff);
    endtask
    task automatic refused_writes();
        do_op(gpio_port_pkg::OP_WRITE, gpio_port_pkg::ADDR_SAMPLED_INPUT, 3'h0, 8'h00);
        do_op(gpio_port_pkg::OP_WRITE, 2'h3, 3'h0, 8'h00);
        rd(gpio_port_pkg::ADDR_DIRECTION, 8'h8f);
        rd(gpio_port_pkg::ADDR_OUTPUT_VALUE, 8'hff);
        rd(2'h3, 8'h00);
    endtask
    task automatic alt_pins();
        alt_owned = 8'h01;
        tick();
        pads(8'h71, 8'h70);
        alt_owned = 8'h00;
        tick();
        pads(8'h70, 8'h70);
    endtask
    task automatic async_reset();
        // reset lands between edges; no edge passes before the check
        rst_n = 1'b0;
        #1;
        pads(8'hff, 8'h00);
        tick();
        tick();
        rst_n = 1'b1;
        tick();
        rd(gpio_port_pkg::ADDR_DIRECTION, 8'h00);
    endtask

    initial begin
        rst_n = 1'b0;
        io_req = '{gpio_port_pkg::OP_NONE, 2'h0, 3'h0, 8'h00};
        global_pullup_disable = 1'b0;
        alt_owned = 8'h00;
        ext_en = 8'hff;
        ext_val = 8'ha5;
        bad_count = 0;
        n_tests = 0;
        repeat (2) @(posedge mclk);
        #2;
        rst_n = 1'b1;
        reset_values();
        pullup_cases();
        output_drive();
        bit_ops();
        refused_writes();
        alt_pins();
        async_reset();
        summarize();
    end

    initial begin
        #100000;
        bad_count++;
        summarize();
    end
endmodule

/* verif/pad_partner.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// external circuitry on the pads
// ----------------------------------------------------------------
module pad_partner (
    // clock
    input  wire logic                        mclk,
    // pad controls from the port
    input  wire gpio_port_pkg::pad_ctrl_type pad_ctrl,
    // external drivers set by the bench
    input  wire logic [7:0]                  ext_en,
    input  wire logic [7:0]                  ext_val,
    // resolved pad levels
    output logic [7:0]                       pad_level
);
    logic float_pat = 1'b0;

    // undriven pads wander each cycle so a stale level is never read as valid
    always @(posedge mclk) float_pat <= ~float_pat;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pad_ctrl.drive_oe_n[i]) begin
                pad_level[i] = pad_ctrl.drive_value[i];
            end else if (ext_en[i]) begin
                pad_level[i] = ext_val[i];
            end else if (pad_ctrl.pullup_en[i]) begin
                pad_level[i] = 1'b1;
            end else begin
                pad_level[i] = float_pat ^ i[0];
            end
        end
    end
endmodule
